// [design/ssc_channel.v]
// Clock-synchronous serial channel: double-buffered transmit and receive on one serial clock
//
// What this block does
// [RQ1] Each character is exactly eight data bits, framed only by clock pulses.
// [RQ2] Transmit output changes on a falling clock edge, held until the next.
// [RQ3] Receive input is sampled on each rising clock edge.
// [RQ4] After eight bits the output stays at the last bit's level.
// [RQ5] No parity or multiprocessor bit is added or expected.
// [RQ6] Transmitter and receiver are independent and share one serial clock.
// [RQ7] Empty flag at zero means holding register loaded; move it to shifter.
// [RQ8] After the move set empty flag, start shifting, request empty interrupt.
// [RQ9] Shift on own clock when internal, on incoming clock when external.
// [RQ10] The empty flag is checked when the last bit is sent.
// [RQ11] Flag zero at check: load next character with no gap.
// [RQ12] Flag one at check: set done flag, hold last bit.
// [RQ13] Done flag set with its enable raises the done interrupt.
// [RQ14] With nothing waiting and the receiver disabled, the serial clock pin is held high.
// [RQ15] Receiver initialises in step with the serial clock, then shifts in.
// [RQ16] Character completed while full flag is one sets the overrun flag.
// [RQ17] Overrun with receive enable raises the receive error interrupt.
// [RQ18] On overrun the new character is dropped and full flag stays one.
// [RQ19] Good character is copied to holding register and full flag set.
// [RQ20] Good reception with receive enable raises the receive full interrupt.
// [RQ21] Host writes the next character before the current one ends.
// [RQ22] Host reads received data before the next character completes.
// [RQ23] Clock-source bit: zero internal clock output, one external clock input.
// [RQ24] Eight-bit divisor resets to all ones, always readable and writable.
// [RQ25] Full flag clears only by writing zero after reading one.
// [RQ26] Bit-order select: zero LSB first, one MSB first.
// [RQ27] Shift only when enabled; host data write clears empty flag.
`include "ssc_defines.vh"

module ssc_channel (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       serial_in,
  output reg        serial_out,
  input  wire       serial_clk_in,
  output reg        serial_clk_out,
  output wire       serial_clk_oe,
  output wire       tx_empty_irq,
  output wire       tx_done_irq,
  output wire       rx_full_irq,
  output wire       rx_error_irq
);
  // Control and status
  reg  [7:0] serial_control_reg;
  reg  [7:0] mode_reg;
  reg  [7:0] bit_rate_divisor_reg;
  reg  [7:0] tx_holding_reg;
  reg  [7:0] rx_holding_reg;
  reg  [7:0] tx_shift_reg;
  reg  [7:0] rx_shift_reg;
  reg        tx_holding_empty_flag;
  reg        tx_done_flag;
  reg        rx_holding_full_flag;
  reg        overrun_flag;
  reg        full_seen;
  reg        ovr_seen;
  reg        done_seen;

  // Serial engine
  reg        active;
  reg  [3:0] tx_bits;
  reg  [3:0] rx_bits;
  reg        tx_busy;
  reg        rx_armed;
  reg        clk_prev;
  reg        tx_empty_evt;

  wire       tx_enable         = serial_control_reg[`SSC_CTRL_TX_EN];
  wire       rx_enable         = serial_control_reg[`SSC_CTRL_RX_EN];
  wire       clock_source_select = serial_control_reg[`SSC_CTRL_CLK_SRC];
  wire       bit_order_select  = mode_reg[`SSC_MODE_ORDER];
  wire [1:0] prescale          = {mode_reg[`SSC_MODE_PRE_HI], mode_reg[`SSC_MODE_PRE_LO]};

  wire       ext_clk_sync;
  wire       half_tick;
  wire       int_rise;
  wire       int_fall;
  wire       ext_rise;
  wire       ext_fall;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       rx_in_sync;
  wire       wr_status;
  wire       rd_status;
  reg        done_evt;
  reg        full_evt;
  reg        ovr_evt;

  // Pins from outside pass two flops before use
  ssc_sync2 u_sync_clk (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (serial_clk_in),
    .dout    (ext_clk_sync)
  );

  ssc_sync2 u_sync_rx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (serial_in),
    .dout    (rx_in_sync)
  );

  ssc_rate_gen u_rate (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .run       (active & ~clock_source_select),
    .prescale  (prescale),
    .divisor   (bit_rate_divisor_reg),
    .half_tick (half_tick)
  );

  function [7:0] order_bits;
    input [7:0] d;
    input       msb_first;
    begin
      order_bits = msb_first ? {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]} : d;
    end
  endfunction

  // Internal clock output is driven only in internal mode, input sampled otherwise
  assign serial_clk_oe = ~clock_source_select;                                  // [RQ23]
  assign int_rise  = half_tick & ~serial_clk_out;
  assign int_fall  = half_tick & serial_clk_out;
  assign ext_rise  = ext_clk_sync & ~clk_prev;
  assign ext_fall  = ~ext_clk_sync & clk_prev;
  assign sclk_rise = clock_source_select ? ext_rise : int_rise;                 // [RQ9]
  assign sclk_fall = clock_source_select ? ext_fall : int_fall;                 // [RQ9] [RQ6]

  assign wr_status = reg_wr & (reg_addr == `SSC_ADDR_STATUS);
  assign rd_status = reg_rd & (reg_addr == `SSC_ADDR_STATUS);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= ext_clk_sync;
    end
  end

  // Internal clock runs while a character is in flight or the receiver is armed
  always @* begin
    active = (tx_busy | rx_armed) & ~(tx_bits == 4'h0 & ~tx_busy & rx_bits == 4'h0 & ~rx_armed);
  end

  // Serial clock generator; idles high
  always @(posedge ref_clk) begin
    if (!rst_n || clock_source_select) begin
      serial_clk_out <= 1'b1;
    end else if (!active) begin
      serial_clk_out <= 1'b1;                                                   // [RQ14]
    end else if (half_tick) begin
      serial_clk_out <= ~serial_clk_out;
    end
  end

  // Transmit path: load, shift on falling edges, check empty flag at last bit
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_shift_reg <= 8'h00;
      tx_bits      <= 4'h0;
      tx_busy      <= 1'b0;
      serial_out   <= 1'b1;
      tx_empty_evt <= 1'b0;
      done_evt     <= 1'b0;
    end else begin
      tx_empty_evt <= 1'b0;
      done_evt     <= 1'b0;
      if (!tx_enable) begin
        tx_busy <= 1'b0;
        tx_bits <= 4'h0;
      end else if (!tx_busy && !tx_holding_empty_flag) begin
        tx_shift_reg <= order_bits(tx_holding_reg, bit_order_select);           // [RQ7] [RQ26]
        tx_bits      <= 4'h0;
        tx_busy      <= 1'b1;
        tx_empty_evt <= 1'b1;                                                   // [RQ8]
      end else if (tx_busy && sclk_rise && tx_bits == `SSC_CHAR_BITS && tx_holding_empty_flag) begin
        // Ending on the last bit's rising edge avoids one stray clock pulse after the frame
        tx_busy  <= 1'b0;                                                       // [RQ10] [RQ12] [RQ4]
        tx_bits  <= 4'h0;
        done_evt <= 1'b1;
      end else if (tx_busy && sclk_fall) begin
        if (tx_bits == `SSC_CHAR_BITS) begin
          // Next character was waiting at the last-bit check; start it with no gap
          tx_shift_reg <= order_bits(tx_holding_reg, bit_order_select) >> 1;    // [RQ11]
          serial_out   <= tx_holding_reg[bit_order_select ? 7 : 0];
          tx_bits      <= 4'h1;
          tx_empty_evt <= 1'b1;
        end else begin
          serial_out   <= tx_shift_reg[0];                                      // [RQ2] [RQ1] [RQ5]
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_bits      <= tx_bits + 4'h1;                                        // [RQ10]
        end
      end
    end
  end

  // Receive path: arm on enable, sample on rising edges
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_shift_reg <= 8'h00;
      rx_bits      <= 4'h0;
      rx_armed     <= 1'b0;
      full_evt     <= 1'b0;
      ovr_evt      <= 1'b0;
    end else begin
      full_evt <= 1'b0;
      ovr_evt  <= 1'b0;
      if (!rx_enable) begin
        rx_armed <= 1'b0;
        rx_bits  <= 4'h0;
      end else if (!rx_armed) begin
        rx_armed <= 1'b1;                                                       // [RQ15]
        rx_bits  <= 4'h0;
      end else if (sclk_rise) begin
        rx_shift_reg <= {rx_in_sync, rx_shift_reg[7:1]};                         // [RQ3] [RQ27]
        if (rx_bits == `SSC_CHAR_BITS - 4'h1) begin
          rx_bits <= 4'h0;
          if (rx_holding_full_flag) begin
            ovr_evt <= 1'b1;                                                    // [RQ16] [RQ18]
          end else begin
            full_evt <= 1'b1;                                                   // [RQ19]
          end
        end else begin
          rx_bits <= rx_bits + 4'h1;
        end
      end
    end
  end

  // Registers, flags and their host-side clearing; hardware set wins over clear, except a data write clearing the empty flag wins
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_control_reg    <= `SSC_CTRL_RESET;
      mode_reg              <= `SSC_MODE_RESET;
      bit_rate_divisor_reg  <= `SSC_DIVISOR_RESET;
      tx_holding_reg        <= 8'h00;
      rx_holding_reg        <= 8'h00;
      tx_holding_empty_flag <= 1'b1;
      tx_done_flag          <= 1'b1;
      rx_holding_full_flag  <= 1'b0;
      overrun_flag          <= 1'b0;
      full_seen             <= 1'b0;
      ovr_seen              <= 1'b0;
      done_seen             <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SSC_ADDR_CTRL)    serial_control_reg   <= reg_wdata;
      if (reg_wr && reg_addr == `SSC_ADDR_MODE)    mode_reg             <= reg_wdata;
      if (reg_wr && reg_addr == `SSC_ADDR_DIVISOR) bit_rate_divisor_reg <= reg_wdata; // [RQ24]
      if (reg_wr && reg_addr == `SSC_ADDR_TXDATA) begin
        tx_holding_reg        <= reg_wdata;
        tx_holding_empty_flag <= 1'b0;                                          // [RQ27]
        tx_done_flag          <= 1'b0;
      end else if (tx_empty_evt) begin
        tx_holding_empty_flag <= 1'b1;                                          // [RQ8]
      end
      if (rd_status) begin
        full_seen <= rx_holding_full_flag;
        ovr_seen  <= overrun_flag;
        done_seen <= tx_done_flag;
      end
      if (done_evt) begin
        tx_done_flag <= 1'b1;                                                   // [RQ12]
      end else if (wr_status && done_seen && !reg_wdata[`SSC_STAT_TX_DONE]) begin
        tx_done_flag <= 1'b0;
      end
      if (full_evt) begin
        rx_holding_reg       <= order_bits(rx_shift_reg, bit_order_select) ;    // [RQ19] [RQ26]
        rx_holding_full_flag <= 1'b1;
      end else if (wr_status && full_seen && !reg_wdata[`SSC_STAT_RX_FULL]) begin
        rx_holding_full_flag <= 1'b0;                                           // [RQ25]
        full_seen            <= 1'b0;
      end
      if (ovr_evt) begin
        overrun_flag <= 1'b1;                                                   // [RQ16]
      end else if (wr_status && ovr_seen && !reg_wdata[`SSC_STAT_OVERRUN]) begin
        overrun_flag <= 1'b0;
        ovr_seen     <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SSC_ADDR_CTRL:    reg_rdata <= serial_control_reg;
        `SSC_ADDR_MODE:    reg_rdata <= mode_reg;
        `SSC_ADDR_DIVISOR: reg_rdata <= bit_rate_divisor_reg;
        `SSC_ADDR_TXDATA:  reg_rdata <= tx_holding_reg;
        `SSC_ADDR_STATUS:  reg_rdata <= {tx_holding_empty_flag, rx_holding_full_flag, overrun_flag,
                                         2'b00, tx_done_flag, 2'b00};
        `SSC_ADDR_RXDATA:  reg_rdata <= rx_holding_reg;
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Interrupt requests are level outputs gated by the enables
  assign tx_empty_irq = tx_holding_empty_flag & serial_control_reg[`SSC_CTRL_TX_EMPTY_IE]; // [RQ8]
  assign tx_done_irq  = tx_done_flag & serial_control_reg[`SSC_CTRL_TX_DONE_IE];           // [RQ13]
  assign rx_full_irq  = rx_holding_full_flag & serial_control_reg[`SSC_CTRL_RX_IE];        // [RQ20]
  assign rx_error_irq = overrun_flag & serial_control_reg[`SSC_CTRL_RX_IE];                // [RQ17]
endmodule

// [design/ssc_defines.vh]
// Register offsets, field positions, reset values and timing counts of the serial channel
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// Register indices on the plain register port
`define SSC_ADDR_CTRL      4'h0
`define SSC_ADDR_MODE      4'h1
`define SSC_ADDR_DIVISOR   4'h2
`define SSC_ADDR_TXDATA    4'h3
`define SSC_ADDR_STATUS    4'h4
`define SSC_ADDR_RXDATA    4'h5

// serial_control_reg fields
`define SSC_CTRL_TX_EMPTY_IE   7
`define SSC_CTRL_RX_IE         6
`define SSC_CTRL_TX_EN         5
`define SSC_CTRL_RX_EN         4
`define SSC_CTRL_TX_DONE_IE    2
`define SSC_CTRL_CLK_SRC       1
`define SSC_CTRL_RESET         8'h01

// Mode register fields
`define SSC_MODE_ORDER     3
`define SSC_MODE_PRE_HI    1
`define SSC_MODE_PRE_LO    0
`define SSC_MODE_RESET     8'h00

// serial_status_reg fields
`define SSC_STAT_TX_EMPTY  7
`define SSC_STAT_RX_FULL   6
`define SSC_STAT_OVERRUN   5
`define SSC_STAT_TX_DONE   2
`define SSC_STAT_RESET     8'h84

`define SSC_DIVISOR_RESET  8'hFF
`define SSC_CHAR_BITS      4'h8

`endif

// [design/ssc_sync2.v]
// Two-flop synchroniser for a pin sampled on ref_clk
module ssc_sync2 (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire din,
  output reg  dout
);
  reg stage1;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// [design/ssc_rate_gen.v]
// Bit-rate generator: prescaler and divisor produce one enable per serial half period
module ssc_rate_gen (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire [1:0] prescale,
  input  wire [7:0] divisor,
  output reg        half_tick
);
  reg [6:0] pre_cnt;
  reg [7:0] div_cnt;
  reg       pre_hit;

  function [6:0] pre_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    pre_limit = 7'h00;
        2'd1:    pre_limit = 7'h03;
        2'd2:    pre_limit = 7'h0F;
        default: pre_limit = 7'h3F;
      endcase
    end
  endfunction

  always @* begin
    pre_hit = (pre_cnt == pre_limit(prescale));
  end

  // Held in reset while idle so the first half period after start is full length
  always @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      pre_cnt   <= 7'h00;
      div_cnt   <= 8'h00;
      half_tick <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      if (pre_hit) begin
        pre_cnt <= 7'h00;
        if (div_cnt == divisor) begin
          div_cnt   <= 8'h00;
          half_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end else begin
        pre_cnt <= pre_cnt + 7'h01;
      end
    end
  end
endmodule

// [verification/ssc_channel_properties.sv]
// Concurrent checks on the ports of the serial channel
`include "ssc_defines.vh"

module ssc_channel_properties (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       serial_in,
  input wire logic       serial_out,
  input wire logic       serial_clk_in,
  input wire logic       serial_clk_out,
  input wire logic       serial_clk_oe,
  input wire logic       tx_empty_irq,
  input wire logic       tx_done_irq,
  input wire logic       rx_full_irq,
  input wire logic       rx_error_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ctrl_q;
  logic [7:0] div_q;
  logic [7:0] done_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Shadows of host writes, so each output can be tied to the setting that governs it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q   <= `SSC_CTRL_RESET;
      div_q    <= `SSC_DIVISOR_RESET;
      done_cnt <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `SSC_ADDR_CTRL) ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == `SSC_ADDR_DIVISOR) div_q <= reg_wdata;
      done_cnt <= !tx_done_irq ? 8'h00 : (done_cnt == 8'hFF ? done_cnt : done_cnt + 8'h01);
    end
  end
  sequence tx_write_s;
    reg_wr && reg_addr == `SSC_ADDR_TXDATA;
  endsequence
  sequence div_read_s;
    reg_rd && reg_addr == `SSC_ADDR_DIVISOR;
  endsequence
  oe_follows_src_a: assert property (serial_clk_oe == !ctrl_q[`SSC_CTRL_CLK_SRC])
    else $error("clock pin enable disagrees with clock source");
  int_out_fall_a: assert property ($changed(serial_out) && serial_clk_oe |-> !serial_clk_out)
    else $error("data changed outside a low clock phase");
  ext_out_fall_a: assert property ($changed(serial_out) && !serial_clk_oe |-> !serial_clk_in)
    else $error("data changed while the external clock was high");
  txe_irq_gate_a: assert property (tx_empty_irq |-> ctrl_q[`SSC_CTRL_TX_EMPTY_IE])
    else $error("empty request without its enable");
  txd_irq_gate_a: assert property (tx_done_irq |-> ctrl_q[`SSC_CTRL_TX_DONE_IE])
    else $error("done request without its enable");
  rx_irq_gate_a: assert property (rx_full_irq || rx_error_irq |-> ctrl_q[`SSC_CTRL_RX_IE])
    else $error("receive request without its enable");
  overrun_keeps_full_a: assert property ($rose(rx_error_irq) |-> rx_full_irq)
    else $error("full flag dropped on overrun");
  divisor_readback_a: assert property (div_read_s |=> reg_rdata == div_q)
    else $error("divisor read back wrong");
  tx_write_done_a: assert property (tx_write_s |=> !tx_done_irq)
    else $error("data write left done set");
  last_bit_hold_a: assert property (done_cnt > 8'h02 |-> $stable(serial_out))
    else $error("line moved after the character ended");
  idle_clk_high_a: assert property (done_cnt > 8'h64 && serial_clk_oe && !ctrl_q[`SSC_CTRL_RX_EN]
                                    |-> serial_clk_out)
    else $error("serial clock not parked high");
endmodule

bind ssc_channel ssc_channel_properties u_props (
  .ref_clk        (ref_clk),
  .rst_n          (rst_n),
  .reg_addr       (reg_addr),
  .reg_wdata      (reg_wdata),
  .reg_wr         (reg_wr),
  .reg_rd         (reg_rd),
  .reg_rdata      (reg_rdata),
  .serial_in      (serial_in),
  .serial_out     (serial_out),
  .serial_clk_in  (serial_clk_in),
  .serial_clk_out (serial_clk_out),
  .serial_clk_oe  (serial_clk_oe),
  .tx_empty_irq   (tx_empty_irq),
  .tx_done_irq    (tx_done_irq),
  .rx_full_irq    (rx_full_irq),
  .rx_error_irq   (rx_error_irq)
);

// [verification/ssc_peer.sv]
// Far-side synchronous serial device sharing the serial clock with the channel
module ssc_peer (
  input  wire logic       ref_oe,
  input  wire logic       dut_clk,
  input  wire logic       dut_out,
  input  wire logic [7:0] peer_byte,
  output wire logic       sclk,
  output logic            peer_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       own_clk = 1'b1;
  logic [7:0] sh;
  logic [7:0] got;
  logic [7:0] got_prev;
  int         bit_n;
  int         got_cnt;
  assign sclk = ref_oe ? dut_clk : own_clk;
  initial peer_out = 1'b0;
  always @(posedge sclk) begin
    sh = {dut_out, sh[7:1]};
    bit_n++;
    if (bit_n == 8) begin
      bit_n = 0;
      got_prev = got;
      got = sh;
      got_cnt++;
    end
  end
  task automatic clear();
    bit_n = 0;
    got_cnt = 0;
  endtask
  // Long low phase leaves room for the channel's pin synchroniser before we sample
  task automatic burst();
    #13;
    for (int i = 0; i < 8; i++) begin
      own_clk = 1'b0;
      peer_out = peer_byte[i];
      #220;
      own_clk = 1'b1;
      #100;
    end
    peer_out = ~peer_out; // Hold time over: show a wrong level, not a stale one
  endtask
endmodule

// [verification/tb_ssc_channel.sv]
// Self-checking bench for the clock-synchronous serial channel
`include "ssc_defines.vh"

module tb_ssc_channel;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic ord; logic [1:0] pre; logic [7:0] d; logic [7:0] e;} ssc_row_t;
  ssc_row_t   rows [6] = '{'{1'b0, 2'h0, 8'h52, 8'h52}, '{1'b1, 2'h0, 8'h52, 8'h4A},
                           '{1'b0, 2'h1, 8'h81, 8'h81}, '{1'b1, 2'h0, 8'h0E, 8'h70},
                           '{1'b0, 2'h2, 8'h45, 8'h45}, '{1'b1, 2'h3, 8'h2E, 8'h74}};
  logic       ref_clk   = 1'b0;
  logic       rst_n     = 1'b0;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] peer_byte = 8'h00;
  wire  [7:0] reg_rdata;
  wire        serial_out, serial_clk_out, serial_clk_oe, sclk, peer_out;
  wire        tx_empty_irq, tx_done_irq, rx_full_irq, rx_error_irq;
  int         miscompares = 0;
  int         compares    = 0;
  int         cyc         = 0;

  ssc_channel DUT (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .serial_in      (peer_out),
    .serial_out     (serial_out),
    .serial_clk_in  (sclk),
    .serial_clk_out (serial_clk_out),
    .serial_clk_oe  (serial_clk_oe),
    .tx_empty_irq   (tx_empty_irq),
    .tx_done_irq    (tx_done_irq),
    .rx_full_irq    (rx_full_irq),
    .rx_error_irq   (rx_error_irq)
  );
  ssc_peer u_peer (
    .ref_oe    (serial_clk_oe),
    .dut_clk   (serial_clk_out),
    .dut_out   (serial_out),
    .peer_byte (peer_byte),
    .sclk      (sclk),
    .peer_out  (peer_out)
  );

  always #20 ref_clk = ~ref_clk;

  task automatic stop_test();
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      $display("FAIL at %0t: got %h, expected %h", $time, got, want);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] want);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, want);
    @(posedge ref_clk);
  endtask
  task automatic waitfor(input int sel, input int n);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (k < 5000 && !(sel == 0 ? tx_done_irq === 1'b1 : sel == 1 ? tx_empty_irq === 1'b1 :
                             sel == 2 ? rx_full_irq === 1'b1 : sel == 4 ? rx_error_irq === 1'b1 :
                             u_peer.got_cnt >= n));
    if (k == 5000) chk(8'h00, 8'h01);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      chk(8'h00, 8'h01);
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    wr(`SSC_ADDR_DIVISOR, 8'h03);
    wr(`SSC_ADDR_CTRL, 8'hA4);
    rdchk(`SSC_ADDR_DIVISOR, 8'h03);
    foreach (rows[i]) begin
      wr(`SSC_ADDR_MODE, {4'h0, rows[i].ord, 1'b0, rows[i].pre});
      u_peer.clear();
      wr(`SSC_ADDR_TXDATA, rows[i].d);
      waitfor(3, 1);
      waitfor(0, 0);
      chk(u_peer.bit_n[7:0], 8'h00);
      chk(u_peer.got, rows[i].e);
      chk({7'h00, serial_out}, {7'h00, rows[i].e[7]});
      rdchk(`SSC_ADDR_STATUS, 8'h84);
    end
    u_peer.clear();
    wr(`SSC_ADDR_MODE, 8'h00);
    wr(`SSC_ADDR_TXDATA, 8'h3C);
    waitfor(1, 0);
    wr(`SSC_ADDR_TXDATA, 8'hC3);
    waitfor(3, 2);
    chk(u_peer.got_prev, 8'h3C);
    chk(u_peer.got, 8'hC3);
    repeat (120) @(posedge ref_clk);
    chk({7'h00, serial_clk_out}, 8'h01);
    u_peer.clear();
    wr(`SSC_ADDR_CTRL, 8'h72);
    chk({7'h00, serial_clk_oe}, 8'h00);
    wr(`SSC_ADDR_TXDATA, 8'h96);
    peer_byte <= 8'h2E;
    u_peer.burst();
    waitfor(2, 0);
    chk(u_peer.got, 8'h96);
    rdchk(`SSC_ADDR_RXDATA, 8'h2E);
    peer_byte <= 8'h71;
    u_peer.burst();
    waitfor(4, 0);
    rdchk(`SSC_ADDR_STATUS, 8'hE4);
    rdchk(`SSC_ADDR_RXDATA, 8'h2E);
    wr(`SSC_ADDR_STATUS, 8'hFF);
    rdchk(`SSC_ADDR_STATUS, 8'hE4);
    wr(`SSC_ADDR_STATUS, 8'h00);
    rdchk(`SSC_ADDR_STATUS, 8'h80);
    wr(`SSC_ADDR_CTRL, 8'h62);
    peer_byte <= 8'h55;
    u_peer.burst();
    repeat (8) @(posedge ref_clk);
    rdchk(`SSC_ADDR_STATUS, 8'h80);
    wr(`SSC_ADDR_CTRL, 8'h72);
    peer_byte <= 8'hA9;
    u_peer.burst();
    waitfor(2, 0);
    rdchk(`SSC_ADDR_RXDATA, 8'hA9);
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({5'h00, serial_out, serial_clk_out, serial_clk_oe}, 8'h07);
    rdchk(`SSC_ADDR_CTRL, 8'h01);
    rdchk(`SSC_ADDR_MODE, 8'h00);
    rdchk(`SSC_ADDR_DIVISOR, 8'hFF);
    rdchk(`SSC_ADDR_STATUS, 8'h84);
    rdchk(4'hF, 8'h00);
    stop_test();
  end
endmodule
